// >>> verilog/acsm_cfg.svh
`ifndef ACSM_CFG_SVH
`define ACSM_CFG_SVH

// Register offsets
`define ACSM_ADDR_STANDBY 8'h00
`define ACSM_ADDR_PROF_A 8'h01
`define ACSM_ADDR_PROF_B 8'h02
`define ACSM_ADDR_PROF_SEL 8'h03

// Reset values
`define ACSM_RST_STANDBY 8'h00
`define ACSM_RST_PROF 8'h0d
`define ACSM_RST_PROF_SEL 8'h00

// Writable bit masks
`define ACSM_MASK_STANDBY 8'h0f
`define ACSM_MASK_PROF 8'h0f
`define ACSM_MASK_PROF_SEL 8'h3f

// Field positions
`define ACSM_FILTER_BIT 3
`define ACSM_SEL_CH0_BIT 0
`define ACSM_SEL_CH1_BIT 1
`define ACSM_SEL_CH2_BIT 4
`define ACSM_SEL_CH3_BIT 5
`define ACSM_HDR_REPEAT_BIT 7

// Timing counts
`define ACSM_MIN_DEC_SHIFT 4'h5
`define ACSM_MAX_DEC_SHIFT 4'ha

`endif

// >>> verilog/acsm_pkg.sv
package acsm_pkg;

  typedef enum logic [2:0] {
    ACSM_DEC_32 = 3'h0,
    ACSM_DEC_64 = 3'h1,
    ACSM_DEC_128 = 3'h2,
    ACSM_DEC_256 = 3'h3,
    ACSM_DEC_512 = 3'h4,
    ACSM_DEC_1024 = 3'h5
  } acsm_dec_t;

  typedef logic [7:0] acsm_byte_t;

endpackage

// >>> verilog/acsm_top.sv
// Function
// - Standby register bits 3..0 put channels 3..0 in standby; reset zero.
// - A channel in standby keeps its slot in the output frame.
// - Standby channel slot carries zero header and zero 24-bit result.
// - Channel 0 standby also turns off the common-mode voltage output.
// - Channel 2 standby also turns off the crystal excitation circuit.
// - Two independent profiles A and B, each filter plus decimation, any channel.
// - Profile bit 3 picks filter: 0 wideband, 1 sinc5; reset 1.
// - Profile bits 2..0 pick decimation x32..x512, codes 5..7 x1024; reset 5.
// - Data-ready pulses at the fastest selected output rate.
// - Slower channels between results give zero data and the repeated flag.
// - Selection bits 0,1,4,5 map channels 0..3 to profile A or B.
// - Register port stays live during standby or sleep.
`timescale 1ns/1ps
`include "acsm_cfg.svh"

module acsm_top
  import acsm_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int DATA_W = 24,
  parameter int HDR_W = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic mod_tick_i,
  input wire logic [NUM_CH*DATA_W-1:0] chan_result_i,
  input wire logic [NUM_CH*HDR_W-1:0] chan_header_i,
  output logic [NUM_CH*(DATA_W+HDR_W)-1:0] frame_o,
  output logic data_ready_o,
  output logic [NUM_CH-1:0] chan_standby_o,
  output logic [NUM_CH-1:0] chan_filter_sinc5_o,
  output logic [NUM_CH*3-1:0] chan_decimation_o,
  output logic common_mode_voltage_output_en_o,
  output logic crystal_excitation_en_o
);

  localparam int SLOT_W = DATA_W + HDR_W;

  acsm_byte_t channel_standby;
  acsm_byte_t profile_a_config;
  acsm_byte_t profile_b_config;
  acsm_byte_t profile_selection;
  logic [9:0] mod_cnt;
  logic [NUM_CH-1:0] chan_prof_b;
  logic [3:0] chan_shift [NUM_CH];
  logic [3:0] fast_shift;
  logic frame_end;
  logic [NUM_CH-1:0] chan_fresh;

  function automatic logic [3:0] dec_shift(input logic [2:0] code);
    logic [3:0] s;
    s = `ACSM_MAX_DEC_SHIFT;
    if (code <= ACSM_DEC_512)
      s = `ACSM_MIN_DEC_SHIFT + {1'b0, code};
    return s;
  endfunction

  function automatic logic [9:0] low_mask(input logic [3:0] sh);
    logic [10:0] m;
    m = (11'h001 << sh) - 11'h001;
    return m[9:0];
  endfunction

  // Write strobes per register; the port stays live in standby and sleep
  logic wr_standby;
  logic wr_prof_a;
  logic wr_prof_b;
  logic wr_prof_sel;

  always_comb
  begin
    wr_standby = 1'b0;
    wr_prof_a = 1'b0;
    wr_prof_b = 1'b0;
    wr_prof_sel = 1'b0;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `ACSM_ADDR_STANDBY: wr_standby = 1'b1;
        `ACSM_ADDR_PROF_A: wr_prof_a = 1'b1;
        `ACSM_ADDR_PROF_B: wr_prof_b = 1'b1;
        `ACSM_ADDR_PROF_SEL: wr_prof_sel = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      channel_standby <= `ACSM_RST_STANDBY;
    else if (wr_standby)
      channel_standby <= reg_wdata_i & `ACSM_MASK_STANDBY;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      profile_a_config <= `ACSM_RST_PROF;
    else if (wr_prof_a)
      profile_a_config <= reg_wdata_i & `ACSM_MASK_PROF;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      profile_b_config <= `ACSM_RST_PROF;
    else if (wr_prof_b)
      profile_b_config <= reg_wdata_i & `ACSM_MASK_PROF;
  end

  // Bits 3 and 2 are kept and read back only; software mirrors bits 5 and 4
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      profile_selection <= `ACSM_RST_PROF_SEL;
    else if (wr_prof_sel)
      profile_selection <= reg_wdata_i & `ACSM_MASK_PROF_SEL;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `ACSM_ADDR_STANDBY: reg_rdata_o <= channel_standby;
        `ACSM_ADDR_PROF_A: reg_rdata_o <= profile_a_config;
        `ACSM_ADDR_PROF_B: reg_rdata_o <= profile_b_config;
        `ACSM_ADDR_PROF_SEL: reg_rdata_o <= profile_selection;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Channel to profile mapping
  always_comb
  begin
    chan_prof_b = '0;
    chan_prof_b[0] = profile_selection[`ACSM_SEL_CH0_BIT];
    chan_prof_b[1] = profile_selection[`ACSM_SEL_CH1_BIT];
    chan_prof_b[2] = profile_selection[`ACSM_SEL_CH2_BIT];
    chan_prof_b[3] = profile_selection[`ACSM_SEL_CH3_BIT];
  end

  always_comb
  begin
    // Standby channels never pace data-ready; all standby falls back to x1024
    fast_shift = `ACSM_MAX_DEC_SHIFT;
    for (int i = 0; i < NUM_CH; i++)
    begin
      chan_standby_o[i] = channel_standby[i];
      chan_filter_sinc5_o[i] = chan_prof_b[i] ? profile_b_config[`ACSM_FILTER_BIT]
                                              : profile_a_config[`ACSM_FILTER_BIT];
      chan_decimation_o[i*3 +: 3] = chan_prof_b[i] ? profile_b_config[2:0] : profile_a_config[2:0];
      chan_shift[i] = dec_shift(chan_decimation_o[i*3 +: 3]);
      if (!channel_standby[i] && chan_shift[i] < fast_shift)
        fast_shift = chan_shift[i];
    end
  end

  assign common_mode_voltage_output_en_o = ~channel_standby[0];
  assign crystal_excitation_en_o = ~channel_standby[2];

  // Modulator sample counter spanning the slowest ratio
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mod_cnt <= 10'h000;
    else if (mod_tick_i)
      mod_cnt <= mod_cnt + 10'h001;
  end

  assign frame_end = mod_tick_i && ((mod_cnt & low_mask(fast_shift)) == low_mask(fast_shift));

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
      chan_fresh[i] = (mod_cnt & low_mask(chan_shift[i])) == low_mask(chan_shift[i]);
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      data_ready_o <= 1'b0;
    else
      data_ready_o <= frame_end;
  end

  // Output frame, channel 0 in the top slot
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      frame_o <= '0;
    else if (frame_end)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (channel_standby[i])
          frame_o[(NUM_CH-1-i)*SLOT_W +: SLOT_W] <= '0;
        else if (chan_fresh[i])
          frame_o[(NUM_CH-1-i)*SLOT_W +: SLOT_W] <= {chan_header_i[i*HDR_W +: HDR_W],
                                                      chan_result_i[i*DATA_W +: DATA_W]};
        else
        begin
          frame_o[(NUM_CH-1-i)*SLOT_W +: SLOT_W] <= '0;
          frame_o[(NUM_CH-1-i)*SLOT_W + DATA_W + `ACSM_HDR_REPEAT_BIT] <= 1'b1;
        end
      end
    end
  end

endmodule // acsm_top

// >>> verif/acsm_props.sv
`timescale 1ns/1ps
module acsm_props (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [127:0] frame_o,
  input wire logic data_ready_o,
  input wire logic [3:0] chan_standby_o,
  input wire logic common_mode_voltage_output_en_o,
  input wire logic crystal_excitation_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_cmv_off: assert property (common_mode_voltage_output_en_o == !chan_standby_o[0])
    else $error("common mode enable");
  chk_xtal_off: assert property (crystal_excitation_en_o == !chan_standby_o[2])
    else $error("xtal enable");
  chk_stby_wr: assert property (reg_wr_i && reg_addr_i == 8'h00 |=> chan_standby_o == $past(reg_wdata_i[3:0]))
    else $error("standby write");
  chk_rd_mask: assert property (reg_rd_i && reg_addr_i == 8'h00 |=>
    reg_rdata_o == {4'h0, $past(chan_standby_o)}) else $error("standby read");
  chk_rd_unmap: assert property (reg_rd_i && reg_addr_i > 8'h03 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read");
  chk_rdy_gap: assert property (data_ready_o |=> !data_ready_o [*8])
    else $error("ready spacing");
  chk_stby_slot: assert property (data_ready_o && $past(chan_standby_o[2]) |-> frame_o[63:32] == 32'h0000_0000)
    else $error("standby slot");
  chk_frame_hold: assert property (!data_ready_o |-> $stable(frame_o))
    else $error("frame hold");
  cover property (data_ready_o);
  cover property (!crystal_excitation_en_o);
  cover property (reg_rd_i && reg_addr_i > 8'h03);
endmodule // acsm_props
bind acsm_top acsm_props u_chk (.*);

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import acsm_pkg::*;
;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} acsm_row_t;
  logic clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, mod_tick_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [95:0] chan_result_i = {4{24'hab_cdef}};
  logic [31:0] chan_header_i = 32'h4433_2211;
  logic [127:0] frame_o;
  logic [11:0] chan_decimation_o;
  logic [3:0] chan_standby_o, chan_filter_sinc5_o;
  logic data_ready_o, common_mode_voltage_output_en_o, crystal_excitation_en_o;
  int n_errors = 0, checks = 0, cyc = 0, gap, nf;
  int ratio [8] = '{32, 64, 128, 256, 512, 1024, 1024, 1024};
  acsm_row_t rows [9] = '{'{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h01, 8'h00, 8'h0d}, '{1'b0, 8'h02, 8'h00, 8'h0d},
    '{1'b0, 8'h03, 8'h00, 8'h00}, '{1'b1, 8'h00, 8'hff, 8'h0f}, '{1'b1, 8'h01, 8'hf2, 8'h02},
    '{1'b1, 8'h03, 8'hff, 8'h3f}, '{1'b1, 8'h07, 8'h55, 8'h00}, '{1'b1, 8'h00, 8'h00, 8'h00}};
  acsm_top uut (.*);
  always #12.5 clk_i = ~clk_i;
  task automatic conclude();
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    cmp("rdata", e, reg_rdata_o);
    @(negedge clk_i);
  endtask
  task automatic wait_rdy();
    gap = 0;
    while (data_ready_o !== 1'b1 && gap < 2000)
    begin
      @(negedge clk_i);
      gap++;
    end
  endtask
  initial
  begin
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h0c);
    wr(8'h03, 8'h3c);
    cmp("profile", 32'h0000_c900, {chan_filter_sinc5_o, chan_decimation_o});
    wr(8'h03, 8'h01);
    wr(8'h00, 8'h05);
    cmp("profile", 32'h0000_1004, {chan_filter_sinc5_o, chan_decimation_o});
    cmp("enables", 32'h0000_0000, {common_mode_voltage_output_en_o, crystal_excitation_en_o});
    cmp("standby", 32'h0000_0005, chan_standby_o);
    rd(8'h00, 8'h05);
    wr(8'h00, 8'h04);
    cmp("enables", 32'h0000_0002, {common_mode_voltage_output_en_o, crystal_excitation_en_o});
    // Ch0 at x512 beside x32 peers: one fresh frame in sixteen
    mod_tick_i = 1'b1;
    nf = 0;
    wait_rdy();
    for (int k = 0; k < 16; k++)
    begin
      @(negedge clk_i);
      wait_rdy();
      cmp("gap", 31, gap);
      cmp("ch1", 32'h22ab_cdef, frame_o[95:64]);
      cmp("ch2", 32'h0000_0000, frame_o[63:32]);
      cmp("ch3", 32'h44ab_cdef, frame_o[31:0]);
      if (frame_o[127:96] === 32'h11ab_cdef)
        nf++;
      else
        cmp("ch0", 32'h8000_0000, frame_o[127:96]);
    end
    cmp("fresh", 1, nf);
    wr(8'h00, 8'h00);
    cmp("enables", 32'h0000_0003, {common_mode_voltage_output_en_o, crystal_excitation_en_o});
    cmp("standby", 32'h0000_0000, chan_standby_o);
    wr(8'h03, 8'h00);
    // Every decimation code on all channels through profile A
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h01, c[7:0]);
      cmp("decim", {4{c[2:0]}}, chan_decimation_o);
      cmp("wideband", 32'h0000_0000, chan_filter_sinc5_o);
      wait_rdy();
      @(negedge clk_i);
      wait_rdy();
      cmp("gap", ratio[c] - 1, gap);
      cmp("ch0", 32'h11ab_cdef, frame_o[127:96]);
      cmp("ch3", 32'h44ab_cdef, frame_o[31:0]);
    end
    // Reset in mid-run
    mod_tick_i = 1'b0;
    nrst_i = 1'b0;
    @(negedge clk_i);
    cmp("rst frame", 32'h0000_0000, frame_o[127:96] | frame_o[95:64] | frame_o[63:32] | frame_o[31:0]);
    cmp("rst ready", 32'h0000_0000, data_ready_o);
    cmp("rst rdata", 32'h0000_0000, reg_rdata_o);
    cmp("rst profile", 32'h0000_fb6d, {chan_filter_sinc5_o, chan_decimation_o});
    cmp("rst standby", 32'h0000_0000, chan_standby_o);
    cmp("rst enables", 32'h0000_0003, {common_mode_voltage_output_en_o, crystal_excitation_en_o});
    nrst_i = 1'b1;
    @(negedge clk_i);
    rd(8'h01, 8'h0d);
    rd(8'h03, 8'h00);
    conclude();
  end
endmodule // tb_top
